// >>> common/pls_defs.svh
// Constants for the panel power link sequencer: offsets, fields, timing.
// Assumes a 50 MHz core clock; included by bare name wherever needed.
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH

// Core clock and millisecond tick
`define PLS_CLK_HZ 50000000
`define PLS_MS_PER_S 1000
`define PLS_CYCLES_PER_MS (`PLS_CLK_HZ / `PLS_MS_PER_S)

// Delay from supply to black video: least and most, in microseconds
`define PLS_BLACK_MIN_US 500
`define PLS_BLACK_MAX_US 200000
// Chosen black video delay in ms (within the window above)
`define PLS_BLACK_MS 8'h01
// Chosen AUX ready delay in ms, not later than hot-plug
`define PLS_AUX_RDY_MS 8'h01
// Chosen hot-plug delay in ms, and its most in ms
`define PLS_HPD_MS 8'h02
`define PLS_HPD_MAX_MS 200
// Video validation time in ms, and its most in ms
`define PLS_VALID_MS 8'h14
`define PLS_VALID_MAX_MS 50

// Status register offset, valid-video field and reset value
`define PLS_STATUS_ADDR 20'h00205
`define PLS_STATUS_VALID_BIT 0
`define PLS_STATUS_RESET 8'h00
// Answer for an unmapped address
`define PLS_UNMAPPED_DATA 8'h00

`endif

// >>> common/pls_pkg.sv
// Types for the panel power link sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package pls_pkg;

  // Sink power and video states, one-hot
  typedef enum logic [4:0] {
    PLS_OFF   = 5'h01, // Panel logic supply absent
    PLS_PWR   = 5'h02, // Supply up, hot-plug not yet raised
    PLS_LINK  = 5'h04, // Hot-plug high, black video, no valid video
    PLS_CHECK = 5'h08, // Valid video arriving, being validated
    PLS_VIDEO = 5'h10  // Valid video on display
  } pls_state_type;

endpackage

// >>> rtl/pls_ms_tick.sv
// Millisecond tick generator for the panel power link sequencer.
// Assumes a free-running core clock; restart realigns the tick phase.
`timescale 1ns/1ps
`include "pls_defs.svh"

module pls_ms_tick import pls_pkg::*; #(
  parameter int unsigned CYCLES_PER_MS = `PLS_CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic restart_i,
  // Tick out
  output logic tick_o
);

  logic [31:0] cnt; // Cycles within the current millisecond
  logic [31:0] next_cnt; // Counter next value
  wire logic at_end; // Last cycle of the millisecond

  assign at_end = (cnt == CYCLES_PER_MS - 1);
  assign next_cnt = (restart_i || at_end) ? 32'h0 : cnt + 32'h1;

  ////////////////////////////////////////////////////////////////////////
  // Counter and tick register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= at_end && !restart_i;
    end
  end

endmodule

// >>> rtl/pls_sequencer.sv
// Sink side power-on and power-off sequencer for an embedded panel link.
// Assumes inputs synchronous to core_clk_i and a source keeping its order.
//
// Summary of operation
// - Black video 0.5 to 200 ms after supply
// - Hot-plug within 200 ms, AUX working first
// - Answer AUX transactions before 200 ms
// - Validate video within 50 ms, set status
// - Video end clears status, black video
// - No-video-stream flag forces black video
// - Debug input disables automatic black video
// - Early AUX polling harmless, source retries
`timescale 1ns/1ps
`include "pls_defs.svh"

module pls_sequencer import pls_pkg::*; #(
  parameter int unsigned CYCLES_PER_MS = `PLS_CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Panel power
  input wire logic panel_logic_supply_i,
  // Link video status from the receiver
  input wire logic video_valid_i,
  input wire logic no_video_stream_i,
  // Debug control
  input wire logic black_auto_off_i,
  // AUX register read port
  input wire logic aux_rd_i,
  input wire logic [19:0] aux_addr_i,
  output logic aux_ack_o,
  output logic aux_defer_o,
  output logic [7:0] aux_rdata_o,
  // Link and panel outputs
  output logic hpd_o,
  output logic aux_ready_o,
  output logic black_video_o,
  output logic video_valid_report_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  pls_state_type state; // Current sequencer state
  pls_state_type next_state; // State next value
  logic [7:0] up_ms; // Milliseconds since supply came up
  logic [7:0] next_up_ms; // Up counter next value
  logic [7:0] val_ms; // Milliseconds of validation so far
  logic [7:0] next_val_ms; // Validation counter next value
  logic black_started; // Black generator has started
  logic [7:0] video_valid_report; // Status register contents
  wire logic ms_tick; // One-cycle pulse each millisecond
  wire logic tick_restart; // Realign tick at power loss
  wire logic black_due; // Black start time reached
  wire logic aux_due; // AUX ready time reached
  wire logic hpd_due; // Hot-plug time reached
  wire logic valid_done; // Validation time reached
  wire logic video_lost; // Valid video ended or flagged absent
  wire logic status_hit; // AUX read hits the status register
  wire logic [7:0] rd_mux; // Read data selection
  wire logic black_want; // Black video wanted this cycle

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick, restarted while the supply is absent
  assign tick_restart = !panel_logic_supply_i;

  pls_ms_tick #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .restart_i(tick_restart),
    .tick_o(ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Power-up milestone decode
  assign black_due = (up_ms >= `PLS_BLACK_MS);
  assign aux_due = (up_ms >= `PLS_AUX_RDY_MS);
  assign hpd_due = (up_ms >= `PLS_HPD_MS) && aux_ready_o;
  assign valid_done = (val_ms >= `PLS_VALID_MS);
  // Either end of valid video or the no-stream flag drops video
  assign video_lost = !video_valid_i || no_video_stream_i;

  ////////////////////////////////////////////////////////////////////////
  // Up counter: saturates, cleared whenever power goes away
  assign next_up_ms = !panel_logic_supply_i ? 8'h00 :
                      (ms_tick && up_ms != 8'hff) ? up_ms + 8'h01 : up_ms;

  // Validation counter: runs only while checking incoming video
  assign next_val_ms = (state != PLS_CHECK) ? 8'h00 :
                       (ms_tick && !valid_done) ? val_ms + 8'h01 : val_ms;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      PLS_OFF: begin
        // Supply rise starts the sequence from the beginning
        if (panel_logic_supply_i) begin
          next_state = PLS_PWR;
        end
      end
      PLS_PWR: begin
        // Raise hot-plug only once AUX already answers
        if (!panel_logic_supply_i) begin
          next_state = PLS_OFF;
        end else if (hpd_due) begin
          next_state = PLS_LINK;
        end
      end
      PLS_LINK: begin
        // Wait for the source to train, idle and send video
        if (!panel_logic_supply_i) begin
          next_state = PLS_OFF;
        end else if (!video_lost) begin
          next_state = PLS_CHECK;
        end
      end
      PLS_CHECK: begin
        // Video must stay valid through the validation time
        if (!panel_logic_supply_i) begin
          next_state = PLS_OFF;
        end else if (video_lost) begin
          next_state = PLS_LINK;
        end else if (valid_done) begin
          next_state = PLS_VIDEO;
        end
      end
      PLS_VIDEO: begin
        // Loss of video returns to black at once
        if (!panel_logic_supply_i) begin
          next_state = PLS_OFF;
        end else if (video_lost) begin
          next_state = PLS_LINK;
        end
      end
      default: begin
        // Recover from an illegal code
        next_state = PLS_OFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State and counters
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= PLS_OFF;
      up_ms <= 8'h00;
      val_ms <= 8'h00;
    end else begin
      state <= next_state;
      up_ms <= next_up_ms;
      val_ms <= next_val_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up flags: black generator, AUX ready, hot-plug
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      black_started <= 1'b0;
      aux_ready_o <= 1'b0;
      hpd_o <= 1'b0;
    end else if (!panel_logic_supply_i) begin
      // Power loss clears everything for a fresh start
      black_started <= 1'b0;
      aux_ready_o <= 1'b0;
      hpd_o <= 1'b0;
    end else begin
      black_started <= black_started || black_due;
      aux_ready_o <= aux_ready_o || aux_due;
      hpd_o <= (next_state != PLS_OFF) && (next_state != PLS_PWR);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Black video and status register
  // Black while started and video not validated, unless debug turns it off
  assign black_want = black_started && (state != PLS_VIDEO) &&
                      !black_auto_off_i;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      black_video_o <= 1'b0;
      video_valid_report <= `PLS_STATUS_RESET;
    end else begin
      black_video_o <= black_want;
      // Valid-video field follows the validated state
      video_valid_report <= `PLS_STATUS_RESET;
      video_valid_report[`PLS_STATUS_VALID_BIT] <= (next_state == PLS_VIDEO);
    end
  end

  assign video_valid_report_o = video_valid_report[`PLS_STATUS_VALID_BIT];

  ////////////////////////////////////////////////////////////////////////
  // AUX read port: decode and answer
  assign status_hit = (aux_addr_i == `PLS_STATUS_ADDR);
  assign rd_mux = status_hit ? video_valid_report : `PLS_UNMAPPED_DATA;

  // Answer one cycle after a read; defer harmlessly before AUX is ready
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_ack_o <= 1'b0;
      aux_defer_o <= 1'b0;
      aux_rdata_o <= 8'h00;
    end else begin
      aux_ack_o <= aux_rd_i && aux_ready_o;
      aux_defer_o <= aux_rd_i && !aux_ready_o;
      if (aux_rd_i && aux_ready_o) begin
        aux_rdata_o <= rd_mux;
      end
    end
  end

endmodule

// >>> dv/pls_sequencer_properties.sv
// Checker for the panel power link sequencer, bound to its top ports.
// Assumes CYCLES_PER_MS of 10 for the cycle bounds below.
`timescale 1ns/1ps

module pls_sequencer_properties #(
  parameter int unsigned CYCLES_PER_MS = 10
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Observed inputs
  input wire logic panel_logic_supply_i,
  input wire logic video_valid_i,
  input wire logic no_video_stream_i,
  input wire logic black_auto_off_i,
  input wire logic aux_rd_i,
  input wire logic [19:0] aux_addr_i,
  // Observed outputs
  input wire logic aux_ack_o,
  input wire logic aux_defer_o,
  input wire logic [7:0] aux_rdata_o,
  input wire logic hpd_o,
  input wire logic aux_ready_o,
  input wire logic black_video_o,
  input wire logic video_valid_report_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////
  black_min_a: assert property ($rose(panel_logic_supply_i) |-> !black_video_o[*5])
    else $error("black video before its least delay");
  black_max_a: assert property ($rose(panel_logic_supply_i) && !black_auto_off_i
    |-> ##[5:40] black_video_o) else $error("black video late");
  hpd_aux_a: assert property (hpd_o |-> aux_ready_o)
    else $error("hot-plug high without AUX ready");
  hpd_max_a: assert property ($rose(panel_logic_supply_i) |-> ##[1:60] hpd_o)
    else $error("hot-plug late");
  aux_answer_a: assert property (aux_rd_i |=> aux_ack_o ^ aux_defer_o)
    else $error("AUX read not answered once");
  early_defer_a: assert property (aux_rd_i && !aux_ready_o |=> aux_defer_o)
    else $error("AUX read not deferred before ready");
  status_read_a: assert property (aux_rd_i && aux_ready_o |=> aux_rdata_o[7:1] == 7'h0)
    else $error("status read upper bits not zero");
  valid_max_a: assert property ($rose(video_valid_i) && hpd_o
    |-> ##[1:510] (video_valid_report_o || !video_valid_i)) else $error("validation late");
  report_drop_a: assert property (video_valid_report_o && !video_valid_i
    |=> !video_valid_report_o) else $error("status kept after video end");
  flag_black_a: assert property (no_video_stream_i && !black_auto_off_i && hpd_o
    ##1 no_video_stream_i |-> ##[0:2] black_video_o) else $error("flag without black");
  supply_loss_a: assert property (!panel_logic_supply_i ##1 !panel_logic_supply_i
    |-> !hpd_o && !aux_ready_o) else $error("outputs kept after supply loss");
  debug_off_a: assert property (black_auto_off_i |=> !black_video_o)
    else $error("black video while debug disable set");
endmodule

bind pls_sequencer pls_sequencer_properties #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
  .core_clk_i, .nrst_i, .panel_logic_supply_i, .video_valid_i, .no_video_stream_i,
  .black_auto_off_i, .aux_rd_i, .aux_addr_i, .aux_ack_o, .aux_defer_o, .aux_rdata_o,
  .hpd_o, .aux_ready_o, .black_video_o, .video_valid_report_o);

// >>> dv/pls_src_model.sv
// Graphics source model: panel supply, link video and backlight order.
// Assumes the bench calls its tasks; drives on the falling edge.
`timescale 1ns/1ps

module pls_src_model #(
  parameter int CPM = 10,
  parameter int IDLE_MS = 2,
  parameter int OFF_MS = 500
) (
  // Clock
  input wire logic core_clk_i,
  // Supply and link video
  output logic panel_logic_supply_o,
  output logic video_valid_o,
  output logic no_video_stream_o
);
  logic led_pwr, dimming, bl_enable; // Backlight controls
  initial begin
    {panel_logic_supply_o, video_valid_o, no_video_stream_o} = 3'h0;
    {led_pwr, dimming, bl_enable} = 3'h0;
  end
  // Millisecond wait counted in falling clock edges, CPM per ms
  task automatic wait_ms(input int ms);
    repeat (ms * CPM) @(negedge core_clk_i);
  endtask
  // Idle for IDLE_MS, then raise valid video
  task automatic video_on();
    wait_ms(IDLE_MS);
    video_valid_o = 1'b1;
  endtask
  // Backlight up only over stable video, 1 ms steps
  task automatic backlight_cycle();
    led_pwr = 1'b1;
    wait_ms(1);
    dimming = 1'b1;
    wait_ms(1);
    bl_enable = 1'b1;
    wait_ms(1);
    bl_enable = 1'b0;
    wait_ms(1);
    dimming = 1'b0;
    wait_ms(1);
    led_pwr = 1'b0;
  endtask
  // Supply removed soon after video ends, then held off
  task automatic power_off();
    wait_ms(1);
    panel_logic_supply_o = 1'b0;
    wait_ms(OFF_MS);
  endtask
endmodule

// >>> dv/pls_sequencer_tb_top.sv
// Bench for the panel power link sequencer: AUX reads and sequence checks.
// Assumes a 20 ns clock and CYCLES_PER_MS of 10.
`timescale 1ns/1ps

module pls_sequencer_tb_top;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, black_auto_off_i = 1'b0, aux_rd_i = 1'b0;
  logic [19:0] aux_addr_i = 20'h0;
  logic sup, vid, nvs, aux_ack_o, aux_defer_o, hpd_o, aux_ready_o, black_video_o, rep;
  logic [7:0] aux_rdata_o;
  int fail_count = 0, samples_checked = 0, cycles = 0, n;
  always #10 core_clk_i = ~core_clk_i;
  pls_src_model src (.core_clk_i, .panel_logic_supply_o(sup), .video_valid_o(vid),
    .no_video_stream_o(nvs));
  pls_sequencer #(.CYCLES_PER_MS(10)) dut (.core_clk_i, .nrst_i, .panel_logic_supply_i(sup),
    .video_valid_i(vid), .no_video_stream_i(nvs), .black_auto_off_i, .aux_rd_i, .aux_addr_i,
    .aux_ack_o, .aux_defer_o, .aux_rdata_o, .hpd_o, .aux_ready_o, .black_video_o,
    .video_valid_report_o(rep));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One AUX read, answer checked a cycle later
  task automatic rd(input logic [19:0] a, input logic dfr, input logic [7:0] d);
    @(negedge core_clk_i);
    aux_rd_i = 1'b1;
    aux_addr_i = a;
    @(negedge core_clk_i);
    aux_rd_i = 1'b0;
    chk("aux_answer", {6'h0, !dfr, dfr}, {6'h0, aux_ack_o, aux_defer_o});
    if (!dfr) chk("aux_rdata", d, aux_rdata_o);
  endtask
  // One status poll; readiness is taken as the request edge will see it
  task automatic poll();
    logic rdy;
    @(negedge core_clk_i);
    aux_rd_i = 1'b1;
    aux_addr_i = 20'h00205;
    rdy = aux_ready_o;
    @(negedge core_clk_i);
    aux_rd_i = 1'b0;
    chk("aux_poll", {6'h0, rdy, !rdy}, {6'h0, aux_ack_o, aux_defer_o});
    if (rdy) chk("aux_poll_data", 8'h00, aux_rdata_o);
  endtask
  task automatic wait_lvl(input int lim);
    for (n = 0; n < lim; n++) @(negedge core_clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge core_clk_i);
    nrst_i = 1'b1;
    rd(20'h00205, 1'b1, 8'h00);
    @(negedge core_clk_i) src.panel_logic_supply_o = 1'b1;
    rd(20'h00205, 1'b1, 8'h00);
    chk("black_early", 8'h00, {7'h0, black_video_o});
    for (n = 0; n < 40 && aux_defer_o !== 1'b0; n++) poll();
    for (n = 0; n < 60 && hpd_o !== 1'b1; n++) @(negedge core_clk_i);
    chk("hpd", 8'h03, {6'h0, hpd_o, aux_ready_o});
    chk("black_on", 8'h01, {7'h0, black_video_o});
    rd(20'h00205, 1'b0, 8'h00);
    src.video_on();
    for (n = 0; n < 510 && rep !== 1'b1; n++) @(negedge core_clk_i);
    wait_lvl(2);
    chk("valid_black", 8'h02, {6'h0, rep, black_video_o});
    rd(20'h00205, 1'b0, 8'h01);
    rd(20'h00206, 1'b0, 8'h00);
    src.backlight_cycle();
    src.video_valid_o = 1'b0;
    wait_lvl(3);
    chk("video_end", 8'h01, {6'h0, rep, black_video_o});
    rd(20'h00205, 1'b0, 8'h00);
    src.video_on();
    // Short video dropout while checking restarts the validation time
    wait_lvl(100);
    src.video_valid_o = 1'b0;
    wait_lvl(2);
    src.video_valid_o = 1'b1;
    wait_lvl(150);
    chk("revalidate", 8'h01, {6'h0, rep, black_video_o});
    for (n = 0; n < 510 && rep !== 1'b1; n++) @(negedge core_clk_i);
    chk("revalid", 8'h01, {7'h0, rep});
    src.no_video_stream_o = 1'b1;
    wait_lvl(3);
    chk("flag_black", 8'h01, {6'h0, rep, black_video_o});
    black_auto_off_i = 1'b1;
    wait_lvl(3);
    chk("debug_off", 8'h00, {7'h0, black_video_o});
    black_auto_off_i = 1'b0;
    src.no_video_stream_o = 1'b0;
    src.video_valid_o = 1'b0;
    src.power_off();
    chk("off", 8'h00, {5'h0, hpd_o, aux_ready_o, black_video_o});
    @(negedge core_clk_i) src.panel_logic_supply_o = 1'b1;
    for (n = 0; n < 60 && hpd_o !== 1'b1; n++) @(negedge core_clk_i);
    chk("restart", 8'h01, {7'h0, hpd_o});
    complete_run();
  end
endmodule
